// ==== hw/dbs_seq.sv ====
// Command sequencer: burst read/write pipelines and self refresh tracking
`include "dbs_cfg.svh"
module dbs_seq #(
	parameter int XSRD_CYCLES = `DBS_XSRD_CYCLES,
	parameter int XSNR_CYCLES = `DBS_XSNR_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] cmd_in,
	input wire logic [`DBS_BANK_W-1:0] bank_in,
	input wire logic [`DBS_COL_W-1:0] col_in,
	input wire logic burst_length_8_in,
	input wire logic [2:0] additive_latency_in,
	input wire logic [2:0] cas_latency_in,
	input wire logic termination_control_in,
	input wire logic [`DBS_WORD_W-1:0] wr_data_in,
	output logic [`DBS_WORD_W-1:0] rd_data_out,
	output logic rd_valid_out,
	output logic wr_sample_out,
	output logic self_refresh_out,
	output logic termination_on_out,
	output logic cmd_error_out,
	output logic [`DBS_BANKS-1:0] banks_open_out
);
	localparam logic [`DBS_CNT_W-1:0] XSRD_LOAD = `DBS_CNT_W'(XSRD_CYCLES);
	localparam logic [`DBS_CNT_W-1:0] XSNR_LOAD = `DBS_CNT_W'(XSNR_CYCLES);
	localparam logic [`DBS_LAT_W-1:0] TAP_MAX = `DBS_LAT_W'(`DBS_PIPE_DEPTH - 1);

	dbs_pkg::dbs_state_t s_reg;
	dbs_pkg::dbs_state_t s_next;
	dbs_mem_if mem ();

	dbs_store u_store (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.mem(mem.store)
	);

	logic [`DBS_LAT_W-1:0] read_latency;
	logic [`DBS_LAT_W-1:0] tap;
	logic [`DBS_COL_W-1:0] burst_mask;
	logic [1:0] burst_left;
	logic ok;
	logic rd_iss;
	logic wr_iss;
	logic [`DBS_BANK_W-1:0] rd_bank;
	logic [`DBS_COL_W-1:0] rd_col;
	logic [`DBS_BANK_W-1:0] wr_bank;
	logic [`DBS_COL_W-1:0] wr_col;
	dbs_pkg::dbs_slot_t new_rd;
	dbs_pkg::dbs_slot_t new_wr;
	dbs_pkg::dbs_slot_t rd_tap;
	dbs_pkg::dbs_slot_t wr_tap;
	dbs_pkg::dbs_cmd_t cmd;

	// Column advance wraps inside the burst, as a sequential burst order does
	function automatic logic [`DBS_COL_W-1:0] burst_next(input logic [`DBS_COL_W-1:0] c,
			input logic [`DBS_COL_W-1:0] m);
		logic [`DBS_COL_W-1:0] inc;
		inc = c + `DBS_COL_W'(1);
		return (c & ~m) | (inc & m);
	endfunction : burst_next

	always_comb begin
		cmd = dbs_pkg::dbs_cmd_t'(cmd_in);
		read_latency = `DBS_LAT_W'(additive_latency_in) + `DBS_LAT_W'(cas_latency_in); // R09
		// Pipe slot k is k+1 clocks old; read issue one clock early for the array register
		tap = read_latency - `DBS_LAT_W'(2); // R08
		if (tap > TAP_MAX) begin
			tap = TAP_MAX;
		end
		burst_mask = burst_length_8_in ? `DBS_MASK_BL8 : `DBS_MASK_BL4;
		burst_left = burst_length_8_in ? `DBS_LEFT_BL8 : `DBS_LEFT_BL4;
		s_next = s_reg;
		new_rd = '0;
		new_wr = '0;
		ok = 1'b1;

		if (s_reg.xsrd_cnt != '0) begin
			s_next.xsrd_cnt = s_reg.xsrd_cnt - `DBS_CNT_W'(1);
		end
		if (s_reg.xsnr_cnt != '0) begin
			s_next.xsnr_cnt = s_reg.xsnr_cnt - `DBS_CNT_W'(1);
		end
		if (s_reg.sr == dbs_pkg::DBS_ST_EXIT && s_reg.xsrd_cnt <= `DBS_CNT_W'(1)) begin
			s_next.sr = dbs_pkg::DBS_ST_ACTIVE;
		end

		// Refused commands raise the error pulse and change nothing, except a termination refusal, which keeps the command's effect
		case (cmd)
			dbs_pkg::DBS_CMD_NOP: begin
				ok = 1'b1;
			end
			dbs_pkg::DBS_CMD_ACT: begin
				ok = s_reg.sr != dbs_pkg::DBS_ST_SREF && !s_reg.open[bank_in]
					&& s_reg.xsnr_cnt == '0; // R07
				if (ok) begin
					s_next.open[bank_in] = 1'b1;
				end
			end
			dbs_pkg::DBS_CMD_RD, dbs_pkg::DBS_CMD_RDA: begin
				ok = s_reg.sr != dbs_pkg::DBS_ST_SREF && s_reg.open[bank_in] // R03
					&& s_reg.xsrd_cnt == '0; // R06
				if (ok) begin
					new_rd = '{valid: 1'b1, bank: bank_in, col: col_in};
					if (cmd == dbs_pkg::DBS_CMD_RDA) begin
						s_next.open[bank_in] = 1'b0;
					end
				end
			end
			dbs_pkg::DBS_CMD_WR, dbs_pkg::DBS_CMD_WRA: begin
				ok = s_reg.sr != dbs_pkg::DBS_ST_SREF && s_reg.open[bank_in] // R03
					&& s_reg.xsnr_cnt == '0; // R07
				if (ok) begin
					new_wr = '{valid: 1'b1, bank: bank_in, col: col_in};
					if (cmd == dbs_pkg::DBS_CMD_WRA) begin
						s_next.open[bank_in] = 1'b0;
					end
				end
			end
			dbs_pkg::DBS_CMD_PRE: begin
				ok = s_reg.sr != dbs_pkg::DBS_ST_SREF && s_reg.xsnr_cnt == '0; // R07
				if (ok) begin
					s_next.open[bank_in] = 1'b0;
				end
			end
			dbs_pkg::DBS_CMD_PREA: begin
				ok = s_reg.sr != dbs_pkg::DBS_ST_SREF && s_reg.xsnr_cnt == '0; // R07
				if (ok) begin
					s_next.open = '0;
				end
			end
			dbs_pkg::DBS_CMD_SRE: begin
				ok = s_reg.sr == dbs_pkg::DBS_ST_ACTIVE && s_reg.open == '0 // R04
					&& !termination_control_in && s_reg.xsnr_cnt == '0; // R05
				if (ok) begin
					s_next.sr = dbs_pkg::DBS_ST_SREF;
				end
			end
			dbs_pkg::DBS_CMD_SRX: begin
				ok = s_reg.sr == dbs_pkg::DBS_ST_SREF;
				if (ok) begin
					s_next.sr = dbs_pkg::DBS_ST_EXIT;
					s_next.xsrd_cnt = XSRD_LOAD; // R06
					s_next.xsnr_cnt = XSNR_LOAD; // R07
				end
			end
			default: begin
				ok = 1'b0;
			end
		endcase

		// Termination stays off from entry until the exit-to-read delay runs out
		if (s_reg.sr != dbs_pkg::DBS_ST_ACTIVE && termination_control_in) begin
			ok = 1'b0; // R05
		end
		s_next.term = termination_control_in && s_reg.sr == dbs_pkg::DBS_ST_ACTIVE; // R05
		s_next.err = !ok;

		s_next.rd_pipe = {s_reg.rd_pipe[`DBS_PIPE_DEPTH-2:0], new_rd};
		s_next.wr_pipe = {s_reg.wr_pipe[`DBS_PIPE_DEPTH-2:0], new_wr};

		// A fresh burst arriving on the clock after the last beat of the previous one gives gapless data
		rd_tap = s_reg.rd_pipe[tap];
		rd_iss = 1'b0;
		rd_bank = s_reg.rd_bank;
		rd_col = s_reg.rd_col;
		s_next.rd_left = 2'h0;
		if (rd_tap.valid) begin // R01
			rd_iss = 1'b1;
			rd_bank = rd_tap.bank;
			rd_col = rd_tap.col;
			s_next.rd_left = burst_left;
		end else if (s_reg.rd_left != 2'h0) begin
			rd_iss = 1'b1;
			rd_col = burst_next(s_reg.rd_col, burst_mask);
			s_next.rd_left = s_reg.rd_left - 2'h1;
		end
		s_next.rd_bank = rd_bank;
		s_next.rd_col = rd_col;

		// Write slot sampled at read latency minus one after the command
		wr_tap = s_reg.wr_pipe[tap]; // R08
		wr_iss = 1'b0;
		wr_bank = s_reg.wr_bank;
		wr_col = s_reg.wr_col;
		s_next.wr_left = 2'h0;
		if (wr_tap.valid) begin // R02
			wr_iss = 1'b1;
			wr_bank = wr_tap.bank;
			wr_col = wr_tap.col;
			s_next.wr_left = burst_left;
		end else if (s_reg.wr_left != 2'h0) begin
			wr_iss = 1'b1;
			wr_col = burst_next(s_reg.wr_col, burst_mask);
			s_next.wr_left = s_reg.wr_left - 2'h1;
		end
		s_next.wr_bank = wr_bank;
		s_next.wr_col = wr_col;
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign mem.re = rd_iss;
	assign mem.raddr = {rd_bank, rd_col};
	assign mem.we = wr_iss;
	assign mem.waddr = {wr_bank, wr_col};
	assign mem.wdata = wr_data_in;

	assign rd_data_out = mem.rdata;
	assign rd_valid_out = mem.rvalid;
	assign wr_sample_out = wr_iss;
	assign self_refresh_out = s_reg.sr == dbs_pkg::DBS_ST_SREF;
	assign termination_on_out = s_reg.term;
	assign cmd_error_out = s_reg.err;
	assign banks_open_out = s_reg.open;
endmodule : dbs_seq

// ==== hw/dbs_cfg.svh ====
// Constants for the burst and self refresh sequencer of a DDR2 device
// Behaviour
// R01: Back-to-back reads every 2 clocks (burst 4) or 4 clocks (burst 8) stream gaplessly.
// R02: Back-to-back writes every 2 clocks (burst 4) or 4 clocks (burst 8) stream gaplessly.
// R03: Seamless bursts allowed across same or different banks, if banks are activated.
// R04: Controller precharges all banks before entering self refresh.
// R05: Termination off before self refresh entry; re-enabled only after exit-to-read delay.
// R06: Reads wait the exit-to-read delay after self refresh exit.
// R07: Other commands wait the exit-to-other delay after self refresh exit.
// R08: Write latency is read latency minus one; write data sampled then.
// R09: Read latency is additive latency plus CAS latency, command to first data.
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH
`define DBS_BANK_W 3
`define DBS_BANKS 8
`define DBS_COL_W 4
`define DBS_WORD_W 16
`define DBS_PIPE_DEPTH 12
`define DBS_LAT_W 4
`define DBS_CNT_W 10
`define DBS_XSRD_CYCLES 200
`define DBS_XSNR_CYCLES 8
`define DBS_LEFT_BL4 2'h1
`define DBS_LEFT_BL8 2'h3
`define DBS_MASK_BL4 4'h1
`define DBS_MASK_BL8 4'h3
`endif

// ==== hw/dbs_pkg.sv ====
// Types shared by the sequencer and its storage
`include "dbs_cfg.svh"
package dbs_pkg;
	typedef enum logic [3:0] {
		DBS_CMD_NOP = 4'h0,
		DBS_CMD_ACT = 4'h1,
		DBS_CMD_RD = 4'h2,
		DBS_CMD_RDA = 4'h3,
		DBS_CMD_WR = 4'h4,
		DBS_CMD_WRA = 4'h5,
		DBS_CMD_PRE = 4'h6,
		DBS_CMD_PREA = 4'h7,
		DBS_CMD_SRE = 4'h8,
		DBS_CMD_SRX = 4'h9
	} dbs_cmd_t;

	// Gray along active -> self refresh -> exit wait; exit wait -> active flips both bits
	typedef enum logic [1:0] {
		DBS_ST_ACTIVE = 2'h0,
		DBS_ST_SREF = 2'h1,
		DBS_ST_EXIT = 2'h3
	} dbs_sr_t;

	typedef struct packed {
		logic valid;
		logic [`DBS_BANK_W-1:0] bank;
		logic [`DBS_COL_W-1:0] col;
	} dbs_slot_t;

	typedef struct packed {
		dbs_sr_t sr;
		logic [`DBS_BANKS-1:0] open;
		dbs_slot_t [`DBS_PIPE_DEPTH-1:0] rd_pipe;
		dbs_slot_t [`DBS_PIPE_DEPTH-1:0] wr_pipe;
		logic [`DBS_BANK_W-1:0] rd_bank;
		logic [`DBS_COL_W-1:0] rd_col;
		logic [1:0] rd_left;
		logic [`DBS_BANK_W-1:0] wr_bank;
		logic [`DBS_COL_W-1:0] wr_col;
		logic [1:0] wr_left;
		logic [`DBS_CNT_W-1:0] xsrd_cnt;
		logic [`DBS_CNT_W-1:0] xsnr_cnt;
		logic err;
		logic term;
	} dbs_state_t;

	typedef struct packed {
		logic rvalid;
		logic [`DBS_WORD_W-1:0] rdata;
	} dbs_store_state_t;
endpackage : dbs_pkg

// ==== hw/dbs_mem_if.sv ====
// Port bundle between the sequencer and its storage array
`include "dbs_cfg.svh"
interface dbs_mem_if;
	logic we;
	logic [`DBS_BANK_W+`DBS_COL_W-1:0] waddr;
	logic [`DBS_WORD_W-1:0] wdata;
	logic re;
	logic [`DBS_BANK_W+`DBS_COL_W-1:0] raddr;
	logic [`DBS_WORD_W-1:0] rdata;
	logic rvalid;
	modport seq (output we, output waddr, output wdata, output re, output raddr,
		input rdata, input rvalid);
	modport store (input we, input waddr, input wdata, input re, input raddr,
		output rdata, output rvalid);
endinterface : dbs_mem_if

// ==== hw/dbs_store.sv ====
// Small data array with registered read port
`include "dbs_cfg.svh"
module dbs_store (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	dbs_mem_if.store mem
);
	localparam int AW = `DBS_BANK_W + `DBS_COL_W;
	logic [`DBS_WORD_W-1:0] array_reg [0:(1<<AW)-1];
	dbs_pkg::dbs_store_state_t s_reg;
	dbs_pkg::dbs_store_state_t s_next;

	always_comb begin
		s_next.rvalid = mem.re;
		s_next.rdata = mem.re ? array_reg[mem.raddr] : s_reg.rdata;
	end

	// Array itself has no reset; contents are undefined until written
	always_ff @(posedge sys_clk_in) begin
		if (mem.we) begin
			array_reg[mem.waddr] <= mem.wdata;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign mem.rdata = s_reg.rdata;
	assign mem.rvalid = s_reg.rvalid;
endmodule : dbs_store

// ==== dv/dbs_seq_properties.sv ====
// Port-level timing checks of the command sequencer
`include "dbs_cfg.svh"
module dbs_seq_properties #(
	parameter int XSRD_CYCLES = 200,
	parameter int XSNR_CYCLES = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] cmd_in,
	input wire logic [`DBS_BANK_W-1:0] bank_in,
	input wire logic burst_length_8_in,
	input wire logic [2:0] additive_latency_in,
	input wire logic [2:0] cas_latency_in,
	input wire logic termination_control_in,
	input wire logic rd_valid_out,
	input wire logic wr_sample_out,
	input wire logic self_refresh_out,
	input wire logic termination_on_out,
	input wire logic cmd_error_out,
	input wire logic [`DBS_BANKS-1:0] banks_open_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] exit_cnt_reg;
	logic rd;
	logic sre;
	logic lat5;
	assign rd = cmd_in == 4'h2;
	assign sre = cmd_in == 4'h8 && !self_refresh_out;
	// Only a read latency of five is tracked
	assign lat5 = additive_latency_in + cas_latency_in == 5;
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	// Cycles since self refresh ended, parked at the top
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			exit_cnt_reg <= 10'h3ff;
		else if (self_refresh_out)
			exit_cnt_reg <= 10'h000;
		else if (exit_cnt_reg != 10'h3ff)
			exit_cnt_reg <= exit_cnt_reg + 10'h001;
	end
	sequence rd_taken;
		rd && banks_open_out[bank_in] && lat5 ##1 !cmd_error_out;
	endsequence
	sequence wr_taken;
		cmd_in == 4'h4 && banks_open_out[bank_in] && lat5 ##1 !cmd_error_out;
	endsequence
	chk_read_latency: assert property (rd_taken |-> ##4 rd_valid_out)
		else $error("read data late or missing");
	chk_read_gapless: assert property (rd_taken ##0 burst_length_8_in |-> ##4 rd_valid_out [*4])
		else $error("long read burst has a gap");
	chk_write_latency: assert property (wr_taken |-> ##3 wr_sample_out ##1 wr_sample_out)
		else $error("write data not taken on time");
	chk_write_gapless: assert property (wr_taken ##0 burst_length_8_in |-> ##3 wr_sample_out [*4])
		else $error("long write burst has a gap");
	chk_closed_bank: assert property (rd && !banks_open_out[bank_in] |=> cmd_error_out)
		else $error("read of closed bank taken");
	chk_entry_idle: assert property (sre && banks_open_out != 0 |=> cmd_error_out && !self_refresh_out)
		else $error("self refresh entered with open bank");
	chk_entry_term: assert property (sre && termination_control_in |=> cmd_error_out)
		else $error("self refresh entered with termination on");
	chk_term_active: assert property (termination_on_out |-> !self_refresh_out && $past(termination_control_in))
		else $error("termination on without request");
	chk_exit_read: assert property (rd && exit_cnt_reg < XSRD_CYCLES |=> cmd_error_out)
		else $error("early read after exit taken");
	chk_exit_other: assert property (cmd_in == 4'h1 && exit_cnt_reg < XSNR_CYCLES |=> cmd_error_out)
		else $error("early activate after exit taken");
endmodule : dbs_seq_properties

bind dbs_seq dbs_seq_properties #(.XSRD_CYCLES(XSRD_CYCLES), .XSNR_CYCLES(XSNR_CYCLES))
	i_dbs_seq_properties (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_in(cmd_in),
	.bank_in(bank_in), .burst_length_8_in(burst_length_8_in),
	.additive_latency_in(additive_latency_in), .cas_latency_in(cas_latency_in),
	.termination_control_in(termination_control_in), .rd_valid_out(rd_valid_out),
	.wr_sample_out(wr_sample_out), .self_refresh_out(self_refresh_out),
	.termination_on_out(termination_on_out), .cmd_error_out(cmd_error_out),
	.banks_open_out(banks_open_out));

// ==== dv/dbs_ctrl_model.sv ====
// Controller stand-in: command driver and write data source
`include "dbs_cfg.svh"
module dbs_ctrl_model (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	output logic [3:0] cmd_out,
	output logic [`DBS_BANK_W-1:0] bank_out,
	output logic [`DBS_COL_W-1:0] col_out,
	output logic [`DBS_WORD_W-1:0] wr_data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cmd_out = 4'h0;
		bank_out = 3'h0;
		col_out = 4'h0;
		wr_data_out = 16'h0000;
	end
	// New word every cycle, so a late or early sample shows
	always @(posedge sys_clk_in) begin
		wr_data_out <= rst_in ? 16'h0000 : wr_data_out + 16'h0001;
	end
	// One command, then idle; n is the spacing to the next one
	task send(input logic [3:0] c, input logic [2:0] b, input logic [3:0] a, input int n,
		output logic [15:0] d);
		@(posedge sys_clk_in);
		cmd_out <= c;
		bank_out <= b;
		col_out <= a;
		#1 d = wr_data_out;
		@(posedge sys_clk_in);
		cmd_out <= 4'h0;
		repeat (n - 2) @(posedge sys_clk_in);
	endtask : send
endmodule : dbs_ctrl_model

// ==== dv/dbs_seq_test.sv ====
// Self-checking bench for the command sequencer
`include "dbs_cfg.svh"
module dbs_seq_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_in;
	logic rst_in;
	logic burst_length_8_in;
	logic termination_control_in;
	logic [3:0] cmd_in;
	logic [2:0] bank_in;
	logic [3:0] col_in;
	logic [15:0] wr_data_in;
	logic [15:0] rd_data_out;
	logic rd_valid_out;
	logic wr_sample_out;
	logic [2:0] additive_latency_in;
	logic [2:0] cas_latency_in;
	logic self_refresh_out;
	logic termination_on_out;
	logic cmd_error_out;
	logic [7:0] banks_open_out;
	logic [15:0] t0;
	logic [15:0] scratch;
	int error_cnt = 0;
	int n_tests = 0;
	dbs_ctrl_model i_dbs_ctrl_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_out(cmd_in),
		.bank_out(bank_in), .col_out(col_in), .wr_data_out(wr_data_in));
	dbs_seq #(.XSRD_CYCLES(12), .XSNR_CYCLES(4)) i_dbs_seq (.sys_clk_in(sys_clk_in),
		.rst_in(rst_in), .cmd_in(cmd_in), .bank_in(bank_in), .col_in(col_in),
		.burst_length_8_in(burst_length_8_in), .additive_latency_in(additive_latency_in),
		.cas_latency_in(cas_latency_in), .termination_control_in(termination_control_in),
		.wr_data_in(wr_data_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.wr_sample_out(wr_sample_out),
		.self_refresh_out(self_refresh_out), .termination_on_out(termination_on_out),
		.cmd_error_out(cmd_error_out), .banks_open_out(banks_open_out));
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task stop_test;
		$display("Errors %0d, checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task step(input logic [3:0] c, input logic [2:0] b, input logic e);
		i_dbs_ctrl_model.send(c, b, 4'h0, 2, scratch);
		#1 chk("cmd_error_out", e, cmd_error_out);
	endtask : step
	task t_reset;
		@(posedge sys_clk_in) #1 chk("banks_open_out", 8'h00, banks_open_out);
		chk("self_refresh_out", 1'b0, self_refresh_out);
	endtask : t_reset
	task t_open;
		step(4'h1, 3'h1, 1'b0);
		step(4'h1, 3'h2, 1'b0);
		chk("banks_open_out", 8'h06, banks_open_out);
		step(4'h1, 3'h1, 1'b1);
		step(4'h2, 3'h3, 1'b1);
	endtask : t_open
	// Two bursts in different banks, spaced for a gapless stream, at a chosen latency
	task t_burst(input logic bl8, input logic [2:0] al, input logic [2:0] cl);
		int w;
		int rl;
		w = bl8 ? 4 : 2;
		rl = int'(al) + int'(cl);
		@(posedge sys_clk_in);
		burst_length_8_in <= bl8;
		additive_latency_in <= al;
		cas_latency_in <= cl;
		fork
			begin
				i_dbs_ctrl_model.send(4'h4, 3'h1, 4'h0, w, t0);
				i_dbs_ctrl_model.send(4'h4, 3'h2, 4'(w), w, scratch);
			end
			begin
				repeat (rl) @(posedge sys_clk_in);
				for (int k = 0; k < 2 * w; k++) begin
					#1 chk("wr_sample_out", 1'b1, wr_sample_out);
					@(posedge sys_clk_in);
				end
				#1 chk("wr_sample_out", 1'b0, wr_sample_out);
			end
		join
		repeat (4) @(posedge sys_clk_in);
		fork
			begin
				i_dbs_ctrl_model.send(4'h2, 3'h1, 4'h0, w, scratch);
				i_dbs_ctrl_model.send(4'h2, 3'h2, 4'(w), w, scratch);
			end
			begin
				repeat (rl + 1) @(posedge sys_clk_in);
				for (int k = 0; k < 2 * w; k++) begin
					#1 chk("rd_valid_out", 1'b1, rd_valid_out);
					chk("rd_data_out", t0 + 16'(rl - 1 + k), rd_data_out);
					@(posedge sys_clk_in);
				end
				#1 chk("rd_valid_out", 1'b0, rd_valid_out);
			end
		join
	endtask : t_burst
	task t_sref;
		@(posedge sys_clk_in) termination_control_in <= 1'b1;
		@(posedge sys_clk_in) #1 chk("termination_on_out", 1'b1, termination_on_out);
		step(4'h8, 3'h0, 1'b1);
		@(posedge sys_clk_in) termination_control_in <= 1'b0;
		step(4'h8, 3'h0, 1'b1);
		step(4'h7, 3'h0, 1'b0);
		step(4'h8, 3'h0, 1'b0);
		chk("self_refresh_out", 1'b1, self_refresh_out);
		step(4'h2, 3'h1, 1'b1);
		step(4'h9, 3'h0, 1'b0);
		chk("self_refresh_out", 1'b0, self_refresh_out);
		step(4'h1, 3'h1, 1'b1);
		@(posedge sys_clk_in);
		step(4'h1, 3'h1, 1'b0);
		step(4'h2, 3'h1, 1'b1);
		repeat (4) @(posedge sys_clk_in);
		step(4'h2, 3'h1, 1'b0);
	endtask : t_sref
	// Auto-precharge forms, single-bank precharge and an undefined code
	task t_misc;
		step(4'h3, 3'h1, 1'b0);
		chk("banks_open_out", 8'h00, banks_open_out);
		step(4'h5, 3'h1, 1'b1);
		step(4'h1, 3'h4, 1'b0);
		step(4'h5, 3'h4, 1'b0);
		step(4'h1, 3'h5, 1'b0);
		chk("banks_open_out", 8'h20, banks_open_out);
		step(4'h6, 3'h5, 1'b0);
		chk("banks_open_out", 8'h00, banks_open_out);
		step(4'hf, 3'h0, 1'b1);
	endtask : t_misc
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	// Whole run is under two hundred cycles
	initial begin
		repeat (3000) @(posedge sys_clk_in);
		error_cnt++;
		stop_test;
	end
	initial begin
		rst_in = 1'b1;
		burst_length_8_in = 1'b0;
		additive_latency_in = 3'h2;
		cas_latency_in = 3'h3;
		termination_control_in = 1'b0;
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_reset;
		t_open;
		t_burst(1'b0, 3'h2, 3'h3);
		t_burst(1'b1, 3'h2, 3'h3);
		t_burst(1'b0, 3'h0, 3'h4);
		t_sref;
		t_misc;
		stop_test;
	end
endmodule : dbs_seq_test
